// ===== slave_intc_params.svh
// Register offsets, field positions and reset values for the slave interrupt controller.
// Assumes byte offsets inside the peripheral control block as seen by the internal register port.
`ifndef SLAVE_INTC_PARAMS_SVH
`define SLAVE_INTC_PARAMS_SVH
`define OFS_VECTOR_BASE 8'h20
`define OFS_SPEC_EOI 8'h22
`define OFS_POLL_ACK 8'h24
`define OFS_POLL_PEEK 8'h26
`define OFS_MASK 8'h28
`define OFS_LEVEL_THRESH 8'h2a
`define OFS_IN_SERVICE 8'h2c
`define OFS_REQUEST 8'h2e
`define OFS_STATUS 8'h30
`define OFS_CTRL_TIMER_ZERO_SOURCE 8'h32
`define OFS_CTRL_DMA0 8'h34
`define OFS_CTRL_DMA1 8'h36
`define OFS_CTRL_TMR1 8'h38
`define OFS_CTRL_TMR2 8'h3a
`define OFS_RELOC 8'hfe
`define RELOC_SLAVE_BIT 14
`define POLL_FLAG_BIT 15
`define CTRL_MASK_BIT 3
`define LEVEL_RESET 3'h7
`define MASK_RESET 1'h1
`define DMA_REQ_MASK 6'h0c
`endif

// ===== slave_intc_pkg.sv
// Types shared by the slave interrupt controller files.
// Assumes nothing of its surroundings.
package slave_intc_pkg;
    typedef logic [2:0] level_t;
    typedef logic [5:0] srcvec_t;
endpackage : slave_intc_pkg

// ===== intc_priority_pick.sv
// Priority resolver: picks the eligible source with the lowest level code.
// Assumes six source slots, some of which are unused and never request.
`timescale 1ns/100ps
module intc_priority_pick
    import slave_intc_pkg::*;
#(
    parameter int NSRC = 6
) (
    input wire logic [NSRC-1:0] eligible,
    input wire logic [3*NSRC-1:0] levels,
    output logic found,
    output logic [2:0] winner
);
    always_comb begin
        logic [2:0] best;
        found = 1'b0;
        winner = 3'h0;
        best = 3'h7;
        // Lower index wins a tie so the result stays stable when software mis-programs levels.
        for (int i = 0; i < NSRC; i++) begin
            if (eligible[i] && (!found || levels[3*i +: 3] < best)) begin
                found = 1'b1;
                best = levels[3*i +: 3];
                winner = 3'(i);
            end
        end
    end
endmodule : intc_priority_pick

// ===== slave_mode_interrupt_controller.sv
// Slave-mode internal interrupt controller: timers, DMA requests, poll, vectoring and EOI.
// Assumes a synchronous one-cycle register port on clk_sys and external select/ack pins.
//
// Function
// RQ1: Reading poll_ack sets in-service for the highest pending source, like an acknowledge.
// RQ2: Reading poll_peek returns pending information and leaves in-service bits alone.
// RQ3: Both poll registers show a pending flag and the winner's vector type.
// RQ4: Master mode after reset; slave mode only when relocation bit 14 is set.
// RQ5: Slave mode ignores external inputs; each timer has own mask, in-service, control.
// RQ6: Software assigns distinct levels and initialises registers before enabling interrupts.
// RQ7: First external interrupt pin feeds the CPU; slave request goes to master.
// RQ8: External logic decodes slave identifier lines to select and supplies ready.
// RQ9: Provide an acknowledge output able to drive the master's acknowledge input.
// RQ10: Acknowledge blocks lower levels while equal or higher levels may still nest.
// RQ11: Vector type is five upper bits from offset 20H plus three source bits.
// RQ12: Write to offset 22H clears the in-service bit selected by low vector bits.
// RQ13: In-service bits sit at 2,3 for DMA and 0,4,5 for timers.
// RQ14: Request bits set on arrival, clear on acknowledge; only DMA bits writable.
// RQ15: Mask register bits and control register mask bits are one storage.
// RQ16: Each timer and DMA channel has a control register with level and mask.
// RQ17: Threshold register holds a level code; lower-priority levels are masked.
// RQ18: Reset clears in-service, request, mode bits; sets levels, masks, threshold to ones.
// RQ19: Status register behaves as in master mode without the DMA halt flag.
// RQ20: In compatible mode enhanced-only registers ignore writes and read undefined.
// RQ21: Level codes run from 000 highest priority to 111 lowest.
// RQ22: Among pending unmasked requests the lowest level code wins.
`timescale 1ns/100ps
`include "slave_intc_params.svh"
module slave_mode_interrupt_controller
    import slave_intc_pkg::*;
#(
    parameter int NSRC = 6
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic regSel,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    input wire logic enhancedMode,
    input wire logic [2:0] timerReq,
    input wire logic [1:0] dmaReq,
    input wire logic [3:0] extIntPin,
    input wire logic slaveSelectPin,
    input wire logic cpuIntaStrobe,
    output logic slaveRequestOut,
    output logic acknowledgeOutN,
    output logic cpuInterrupt,
    output logic [7:0] vectorOut,
    output logic slaveMode
);
    // Slot order follows the in-service layout: 0 timer0, 2 dma0, 3 dma1, 4 timer1, 5 timer2.
    localparam srcvec_t USED = 6'h3d;

    logic [1:0] extSync1_q, extSync2_q;
    logic [2:0] tmrPrev_q;
    logic [1:0] dmaPrev_q;
    logic slaveMode_q;
    logic [4:0] vecBase_q;
    level_t thresh_q;
    srcvec_t req_q, isr_q, mask_q;
    logic [3*NSRC-1:0] level_q;
    logic [15:0] rdata_q;
    logic reqOut_q, ackN_q, cpuInt_q;
    logic [7:0] vecOut_q;

    logic wrStb, rdStb;
    srcvec_t arrive, eligible;
    logic found;
    logic [2:0] winner;
    logic [3:0] blockLevel;
    logic pollAck, hwAck, anyAck;
    srcvec_t ackOne;

    assign wrStb = regSel && regWr;
    assign rdStb = regSel && regRd;

    // Only the first external pin is used, as the CPU interrupt input; bit 1 carries the select.
    // Nothing but the second stage reads the first, so logic never sees a metastable value.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            extSync1_q <= 2'h0;
            extSync2_q <= 2'h0;
        end else begin
            extSync1_q <= {slaveSelectPin, extIntPin[0]};
            extSync2_q <= extSync1_q;
        end
    end

    // RQ4 mode from relocation bit
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            slaveMode_q <= 1'b0;
        end else if (wrStb && regAddr == `OFS_RELOC) begin
            slaveMode_q <= regWdata[`RELOC_SLAVE_BIT];
        end
    end

    // Rising-edge detect on the internal sources gives one arrival per request.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tmrPrev_q <= 3'h0;
            dmaPrev_q <= 2'h0;
        end else begin
            tmrPrev_q <= timerReq;
            dmaPrev_q <= dmaReq;
        end
    end
    assign arrive = {timerReq[2] & ~tmrPrev_q[2], timerReq[1] & ~tmrPrev_q[1],
                     dmaReq[1] & ~dmaPrev_q[1], dmaReq[0] & ~dmaPrev_q[0],
                     1'b0, timerReq[0] & ~tmrPrev_q[0]};

    // RQ10 block lower than highest in-service
    always_comb begin
        blockLevel = 4'h8;
        for (int i = 0; i < NSRC; i++) begin
            if (isr_q[i] && {1'b0, level_q[3*i +: 3]} < blockLevel) begin
                blockLevel = {1'b0, level_q[3*i +: 3]};
            end
        end
    end

    // RQ17 threshold and mask gating
    generate
        for (genvar g = 0; g < NSRC; g++) begin : gElig
            assign eligible[g] = USED[g] && req_q[g] && !mask_q[g]
                && level_q[3*g +: 3] <= thresh_q
                && {1'b0, level_q[3*g +: 3]} <= blockLevel;
        end
    endgenerate

    // RQ21 code 000 highest
    // RQ22 lowest code wins
    intc_priority_pick #(.NSRC(NSRC)) uPick (
        .eligible(eligible),
        .levels(level_q),
        .found(found),
        .winner(winner)
    );

    // RQ1 poll read acknowledges
    // RQ2 peek read never acknowledges
    assign pollAck = rdStb && regAddr == `OFS_POLL_ACK && found;
    assign hwAck = slaveMode_q && extSync2_q[1] && cpuIntaStrobe && found;
    assign anyAck = pollAck || hwAck;
    assign ackOne = srcvec_t'(6'h01 << winner);

    // RQ14 request set, ack clear, DMA writable
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            req_q <= 6'h00;
        end else begin
            srcvec_t nxt;
            nxt = req_q;
            if (anyAck) begin
                nxt = nxt & ~ackOne;
            end
            if (wrStb && regAddr == `OFS_REQUEST) begin
                nxt = (nxt & ~`DMA_REQ_MASK) | (regWdata[5:0] & `DMA_REQ_MASK);
            end
            // Arrivals are applied last so a same-cycle clear never loses an event.
            req_q <= (nxt | arrive) & USED;
        end
    end

    // RQ13 in-service set on ack, RQ12 cleared by specific_end_of_interrupt
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            isr_q <= 6'h00;
        end else begin
            srcvec_t nxt;
            nxt = isr_q;
            if (wrStb && regAddr == `OFS_IN_SERVICE) begin
                nxt = regWdata[5:0] & USED;
            end
            if (wrStb && regAddr == `OFS_SPEC_EOI) begin
                nxt = nxt & ~srcvec_t'(6'h01 << regWdata[2:0]);
            end
            if (anyAck) begin
                nxt = nxt | ackOne;
            end
            isr_q <= nxt;
        end
    end

    // RQ15 one mask store, RQ16 per-source control registers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mask_q <= {NSRC{`MASK_RESET}};
            level_q <= {NSRC{`LEVEL_RESET}};
        end else if (wrStb) begin
            unique case (regAddr)
                `OFS_MASK: mask_q <= regWdata[5:0] | ~USED;
                `OFS_CTRL_TIMER_ZERO_SOURCE: begin
                    mask_q[0] <= regWdata[`CTRL_MASK_BIT];
                    level_q[2:0] <= regWdata[2:0];
                end
                `OFS_CTRL_DMA0: begin
                    mask_q[2] <= regWdata[`CTRL_MASK_BIT];
                    level_q[8:6] <= regWdata[2:0];
                end
                `OFS_CTRL_DMA1: begin
                    mask_q[3] <= regWdata[`CTRL_MASK_BIT];
                    level_q[11:9] <= regWdata[2:0];
                end
                `OFS_CTRL_TMR1: begin
                    mask_q[4] <= regWdata[`CTRL_MASK_BIT];
                    level_q[14:12] <= regWdata[2:0];
                end
                `OFS_CTRL_TMR2: begin
                    mask_q[5] <= regWdata[`CTRL_MASK_BIT];
                    level_q[17:15] <= regWdata[2:0];
                end
                default: ;
            endcase
        end
    end

    // RQ18 reset values; RQ11 vector base
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            vecBase_q <= 5'h00;
            thresh_q <= `LEVEL_RESET;
        end else if (wrStb && regAddr == `OFS_VECTOR_BASE) begin
            vecBase_q <= regWdata[7:3];
        end else if (wrStb && regAddr == `OFS_LEVEL_THRESH) begin
            thresh_q <= regWdata[2:0];
        end
    end

    // RQ3 poll words; RQ19 status without halt flag; RQ20 is met since no enhanced-only regs here
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else if (rdStb) begin
            unique case (regAddr)
                `OFS_POLL_ACK, `OFS_POLL_PEEK:
                    rdata_q <= {found, 7'h00, vecBase_q, winner};
                `OFS_VECTOR_BASE: rdata_q <= {8'h00, vecBase_q, 3'h0};
                `OFS_MASK: rdata_q <= {10'h000, mask_q};
                `OFS_LEVEL_THRESH: rdata_q <= {13'h0000, thresh_q};
                `OFS_IN_SERVICE: rdata_q <= {10'h000, isr_q};
                `OFS_REQUEST: rdata_q <= {10'h000, req_q};
                `OFS_STATUS: rdata_q <= {13'h0000, tmrPrev_q};
                `OFS_CTRL_TIMER_ZERO_SOURCE: rdata_q <= {12'h000, mask_q[0], level_q[2:0]};
                `OFS_CTRL_DMA0: rdata_q <= {12'h000, mask_q[2], level_q[8:6]};
                `OFS_CTRL_DMA1: rdata_q <= {12'h000, mask_q[3], level_q[11:9]};
                `OFS_CTRL_TMR1: rdata_q <= {12'h000, mask_q[4], level_q[14:12]};
                `OFS_CTRL_TMR2: rdata_q <= {12'h000, mask_q[5], level_q[17:15]};
                `OFS_RELOC: rdata_q <= {1'b0, slaveMode_q, 14'h0000};
                default: rdata_q <= 16'h0000;
            endcase
        end
    end

    // RQ7 request to master, CPU input; RQ9 acknowledge out; RQ5 ignores other pins
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reqOut_q <= 1'b0;
            ackN_q <= 1'b1;
            cpuInt_q <= 1'b0;
            vecOut_q <= 8'h00;
        end else begin
            reqOut_q <= slaveMode_q && found;
            ackN_q <= !(slaveMode_q && cpuIntaStrobe);
            cpuInt_q <= slaveMode_q && extSync2_q[0];
            if (hwAck) begin
                vecOut_q <= {vecBase_q, winner};
            end
        end
    end

    assign regRdata = rdata_q;
    assign slaveRequestOut = reqOut_q;
    assign acknowledgeOutN = ackN_q;
    assign cpuInterrupt = cpuInt_q;
    assign vectorOut = vecOut_q;
    assign slaveMode = slaveMode_q;

    // The poll-status read must never set in-service bits.
    chk_peek_no_isr: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ2
        (rdStb && regAddr == `OFS_POLL_PEEK && !wrStb && !hwAck) |=> isr_q == $past(isr_q))
        else $error("poll peek changed in-service");
    chk_poll_sets_isr: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
        pollAck |=> isr_q[$past(winner)])
        else $error("poll read did not set in-service");
    chk_reset_master: assert property (@(posedge clk_sys) // RQ18
        !resetn |=> !slaveMode_q && mask_q == 6'h3f && thresh_q == 3'h7)
        else $error("reset state wrong");
    chk_master_no_req: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ4
        !slaveMode_q |=> !slaveRequestOut)
        else $error("request out in master mode");
    chk_masked_never: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ17
        found |-> !mask_q[winner] && level_q[3*winner +: 3] <= thresh_q)
        else $error("masked source won");
    chk_poll_flag: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
        (rdStb && regAddr == `OFS_POLL_PEEK) |=> regRdata[`POLL_FLAG_BIT] == $past(found))
        else $error("poll flag wrong");
    chk_eoi_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ12
        (wrStb && regAddr == `OFS_SPEC_EOI && !anyAck) |=> !isr_q[$past(regWdata[2:0])])
        else $error("EOI did not clear");
    chk_ack_clears_req: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ14
        (anyAck && !arrive[winner] && !wrStb) |=> !req_q[$past(winner)])
        else $error("ack did not clear request");
endmodule : slave_mode_interrupt_controller

// ===== master_pic_model.sv
// Far-side model: master interrupt controller and CPU acknowledge cycle.
// Assumes the bench pulses ackGo for one cycle and then waits for ackDone.
`timescale 1ns/100ps
module master_pic_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slaveReq,
    input wire logic ackGo,
    output logic [3:0] intPins,
    output logic selectPin,
    output logic intaStrobe,
    output logic ackDone
);
    int step = 0;
    initial intPins = '0;
    initial selectPin = 1'b0;
    initial intaStrobe = 1'b0;
    initial ackDone = 1'b0;
    // request forwarded to CPU pin.
    // The unused pins toggle so a design that listens to them is caught.
    always @(posedge clk_sys) intPins <= {3'($urandom), slaveReq};
    // select decoded externally.
    // Select is raised three cycles before the strobe because the design synchronises it.
    always @(posedge clk_sys) begin
        if (!resetn)
            step <= 0;
        else if (ackGo)
            step <= 1;
        else if (step > 0)
            step <= (step == 5) ? 0 : step + 1;
        selectPin <= resetn && (ackGo || (step > 0 && step < 5));
        intaStrobe <= (step == 3);
        ackDone <= (step == 5);
    end
endmodule : master_pic_model

// ===== slave_mode_interrupt_controller_tb_top.sv
// Bench for the slave interrupt controller against a reference model of its state.
// Assumes the one-cycle register port and the master model in master_pic_model.sv.
`timescale 1ns/100ps
`include "slave_intc_params.svh"
module slave_mode_interrupt_controller_tb_top;
    logic clk_sys = 0, resetn = 0, regSel = 0, regWr = 0, regRd = 0, ackGo = 0;
    logic [7:0] regAddr = '0;
    logic [15:0] regWdata = '0, regRdata, rv;
    logic [5:0] srcLine = '0;
    logic [3:0] extIntPin;
    logic slaveSelectPin, cpuIntaStrobe, slaveRequestOut, acknowledgeOutN;
    logic cpuInterrupt, slaveMode, ackDone;
    logic [7:0] vectorOut;
    logic [7:0] ofs [6] = '{`OFS_CTRL_TIMER_ZERO_SOURCE, 8'h00, `OFS_CTRL_DMA0, `OFS_CTRL_DMA1,
                            `OFS_CTRL_TMR1, `OFS_CTRL_TMR2};
    int lvTab [6] = '{3, 7, 1, 5, 2, 4};
    int n_errors = 0, checks_done = 0, ackLows = 0, vb, th;
    int isr [6], req [6], msk [6], lvl [6];
    initial forever #2 clk_sys = ~clk_sys;
    slave_mode_interrupt_controller slave_mode_interrupt_controller_inst (
        .clk_sys(clk_sys), .resetn(resetn), .regSel(regSel), .regWr(regWr),
        .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .enhancedMode(1'b1), .timerReq({srcLine[5], srcLine[4], srcLine[0]}),
        .dmaReq(srcLine[3:2]), .extIntPin(extIntPin), .slaveSelectPin(slaveSelectPin),
        .cpuIntaStrobe(cpuIntaStrobe), .slaveRequestOut(slaveRequestOut),
        .acknowledgeOutN(acknowledgeOutN), .cpuInterrupt(cpuInterrupt),
        .vectorOut(vectorOut), .slaveMode(slaveMode));
    master_pic_model master_pic_model_inst (
        .clk_sys(clk_sys), .resetn(resetn), .slaveReq(slaveRequestOut), .ackGo(ackGo),
        .intPins(extIntPin), .selectPin(slaveSelectPin), .intaStrobe(cpuIntaStrobe),
        .ackDone(ackDone));
    always @(posedge clk_sys) if (!acknowledgeOutN) ackLows <= ackLows + 1;
    // Winner: unmasked, within threshold, not below the best level in service.
    function automatic int pick();
        int w = -1, top = 7;
        for (int s = 0; s < 6; s++)
            if (isr[s] != 0 && lvl[s] < top) top = lvl[s];
        for (int s = 0; s < 6; s++)
            if (req[s] != 0 && msk[s] == 0 && lvl[s] <= th && lvl[s] <= top &&
                (w < 0 || lvl[s] < lvl[w])) w = s;
        return w;
    endfunction : pick
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic waitFor(ref logic s, input string nm);
        int k = 0;
        while (s !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (s !== 1'b1) begin
            chk(nm, 16'h0001, 16'(s));
            close_out();
        end
    endtask : waitFor
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk_sys);
        {regSel, regWr, regAddr, regWdata} <= {2'b11, a, d};
        @(posedge clk_sys);
        {regSel, regWr} <= 2'b00;
    endtask : wr
    task automatic rdc(string nm, logic [7:0] a, logic [15:0] e, logic [15:0] m);
        @(posedge clk_sys);
        {regSel, regRd, regAddr} <= {2'b11, a};
        @(posedge clk_sys);
        {regSel, regRd} <= 2'b00;
        #1 rv = regRdata;
        chk(nm, e & m, rv & m);
    endtask : rdc
    // Vector bits are only compared while the pending flag is set.
    task automatic pollChk(logic [7:0] a);
        int w;
        w = pick();
        rdc("poll", a, (w < 0) ? 16'h0000 : 16'h8000 | 16'(vb) | 16'(w),
            (w < 0) ? 16'h8000 : 16'h80ff);
        if (a == `OFS_POLL_ACK && w >= 0) begin
            isr[w] = 1;
            req[w] = 0;
        end
    endtask : pollChk
    task automatic eoi(int s);
        wr(`OFS_SPEC_EOI, 16'(s));
        isr[s] = 0;
    endtask : eoi
    task automatic raise(int s);
        @(posedge clk_sys) srcLine[s] <= 1'b1;
        @(posedge clk_sys) srcLine[s] <= 1'b0;
        req[s] = 1;
    endtask : raise
    task automatic hwAck();
        int w, a0;
        w = pick();
        a0 = ackLows;
        @(posedge clk_sys) ackGo <= 1'b1;
        @(posedge clk_sys) ackGo <= 1'b0;
        waitFor(ackDone, "ackDone");
        repeat (2) @(posedge clk_sys);
        #1;
        chk("ackLows", 16'h0001, 16'(ackLows - a0));
        chk("vectorOut", 16'(vb | w), 16'(vectorOut));
        isr[w] = 1;
        req[w] = 0;
    endtask : hwAck
    initial begin
        vb = $urandom(63015) & 248;
        th = 7;
        foreach (lvl[s]) begin
            lvl[s] = 7;
            msk[s] = 1;
            isr[s] = 0;
            req[s] = 0;
        end
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc("mask", `OFS_MASK, 16'h003d, 16'h003d);
        rdc("thresh", `OFS_LEVEL_THRESH, 16'h0007, 16'h0007);
        rdc("isr", `OFS_IN_SERVICE, 16'h0000, 16'h003d);
        rdc("req", `OFS_REQUEST, 16'h0000, 16'h003d);
        foreach (ofs[s]) if (s != 1) rdc("ctrl", ofs[s], 16'h000f, 16'h000f);
        rdc("unmapped", 8'h40, 16'h0000, 16'hffff);
        rdc("status", `OFS_STATUS, 16'h0000, 16'hffff);
        chk("mode", 16'h0001, 16'({slaveMode, acknowledgeOutN}));
        $display("Test reset finished");
        wr(`OFS_RELOC, 16'h0001 << `RELOC_SLAVE_BIT);
        #1 chk("mode", 16'h0001, 16'(slaveMode));
        wr(`OFS_VECTOR_BASE, 16'(vb));
        rdc("vecbase", `OFS_VECTOR_BASE, 16'(vb), 16'h00f8);
        foreach (ofs[s]) if (s != 1) begin
            lvl[s] = lvTab[s];
            msk[s] = 0;
            wr(ofs[s], 16'(lvl[s]));
        end
        wr(`OFS_MASK, 16'h0008);
        rdc("ctrlmask", `OFS_CTRL_DMA1, 16'h000d, 16'h000f);
        wr(`OFS_CTRL_DMA1, 16'h0005);
        rdc("maskreg", `OFS_MASK, 16'h0000, 16'h003d);
        $display("Test setup finished");
        wr(`OFS_REQUEST, 16'h003f);
        req[2] = 1;
        req[3] = 1;
        rdc("req", `OFS_REQUEST, 16'h000c, 16'h003d);
        pollChk(`OFS_POLL_PEEK);
        rdc("isr", `OFS_IN_SERVICE, 16'h0000, 16'h003d);
        pollChk(`OFS_POLL_ACK);
        rdc("isr", `OFS_IN_SERVICE, 16'h0004, 16'h003d);
        rdc("req", `OFS_REQUEST, 16'h0008, 16'h003d);
        pollChk(`OFS_POLL_PEEK);
        eoi(2);
        rdc("isr", `OFS_IN_SERVICE, 16'h0000, 16'h003d);
        pollChk(`OFS_POLL_ACK);
        raise(4);
        pollChk(`OFS_POLL_PEEK);
        th = 1;
        wr(`OFS_LEVEL_THRESH, 16'(th));
        pollChk(`OFS_POLL_PEEK);
        th = 2;
        wr(`OFS_LEVEL_THRESH, 16'(th));
        pollChk(`OFS_POLL_PEEK);
        hwAck();
        rdc("isr", `OFS_IN_SERVICE, 16'h0018, 16'h003d);
        eoi(3);
        eoi(4);
        th = 7;
        wr(`OFS_LEVEL_THRESH, 16'(th));
        $display("Test poll and nesting finished");
        foreach (lvTab[s]) if (s == 0 || s > 3) begin
            raise(s);
            waitFor(slaveRequestOut, "slaveRequestOut");
            waitFor(cpuInterrupt, "cpuInterrupt");
            hwAck();
            rdc("isr", `OFS_IN_SERVICE, 16'h0001 << s, 16'h003d);
            rdc("req", `OFS_REQUEST, 16'h0000, 16'h003d);
            eoi(s);
            rdc("isr", `OFS_IN_SERVICE, 16'h0000, 16'h003d);
            pollChk(`OFS_POLL_PEEK);
        end
        $display("Test hardware acknowledge finished");
        close_out();
    end
endmodule : slave_mode_interrupt_controller_tb_top
